// >>> src/trps_pkg.sv
// Package of constants and types for the three-rail power sequencer
package trps_pkg;
	// Power-up hold time in nanoseconds and the derived cycle count
	localparam int POWERUP_HOLD_NS = 100000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int POWERUP_HOLD_CYC = (POWERUP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Time-based gap between core and I/O rail edges
	localparam int SEQ_GAP_NS = 10000;
	localparam int SEQ_GAP_CYC = (SEQ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Serial slave: fixed upper address bits, command codes, status layout
	localparam logic [3:0] SLAVE_ADDR_HI = 4'h4;
	localparam logic [7:0] CMD_STATUS = 8'h01;
	localparam logic [7:0] CMD_OFF = 8'h02;
	localparam int ST_PRIMARY_BIT = 0;
	localparam int ST_CORE_BIT = 1;
	localparam int ST_IO_BIT = 2;
	localparam int ST_READY_BIT = 3;
	localparam logic [2:0] OFF_NONE = 3'h0;

	typedef enum logic [4:0] {
		TRPS_OFF = 5'h01,
		TRPS_CORE_UP = 5'h02,
		TRPS_ALL_UP = 5'h04,
		TRPS_IO_DOWN = 5'h08,
		TRPS_CORE_DOWN = 5'h10
	} trps_seq_t;

	typedef enum logic [5:0] {
		TRPS_IDLE = 6'h01,
		TRPS_ADDR = 6'h02,
		TRPS_CMD = 6'h04,
		TRPS_DATA = 6'h08,
		TRPS_RDBYTE = 6'h10,
		TRPS_ACK = 6'h20
	} trps_bus_t;
endpackage : trps_pkg

// >>> src/trps_ctl_if.sv
// Interface between the sequencer core and its serial slave
`timescale 1ns/1ps
interface trps_ctl_if;
	logic [2:0] railStatus;
	logic readyState;
	logic [2:0] offRequest;
	logic offStrobe;
	modport core (input offRequest, input offStrobe, output railStatus, output readyState);
	modport slave (output offRequest, output offStrobe, input railStatus, input readyState);
endinterface : trps_ctl_if

// >>> src/trps_smbus_slave.sv
// Serial bus slave: status read and switch turn-off commands
`timescale 1ns/1ps
module trps_smbus_slave
	import trps_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic sclSync,
	input wire logic sdaSync,
	input wire logic [2:0] slaveAddr,
	output logic sdaOe,
	trps_ctl_if.slave ctl
);
	trps_bus_t state;
	trps_bus_t retState;
	logic sclPrev;
	logic sdaPrev;
	logic [7:0] shiftReg;
	logic [3:0] bitCount;
	logic [7:0] command;
	wire sclRise = sclSync && !sclPrev;
	wire sclFall = !sclSync && sclPrev;
	wire startCond = sclSync && sdaPrev && !sdaSync;
	wire stopCond = sclSync && !sdaPrev && sdaSync;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end else begin
			sclPrev <= sclSync;
			sdaPrev <= sdaSync;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state <= TRPS_IDLE;
			retState <= TRPS_IDLE;
			shiftReg <= 8'h00;
			bitCount <= 4'h0;
			command <= 8'h00;
			sdaOe <= 1'b0;
			ctl.offRequest <= OFF_NONE;
			ctl.offStrobe <= 1'b0;
		end else begin
			ctl.offStrobe <= 1'b0;
			if (startCond) begin
				state <= TRPS_ADDR;
				bitCount <= 4'h0;
				sdaOe <= 1'b0;
			end else if (stopCond) begin
				state <= TRPS_IDLE;
				sdaOe <= 1'b0;
			end else begin
				case (state)
				TRPS_IDLE: begin
					sdaOe <= 1'b0;
				end
				TRPS_ADDR, TRPS_CMD, TRPS_DATA: begin
					if (sclRise) begin
						shiftReg <= {shiftReg[6:0], sdaSync};
						bitCount <= bitCount + 4'h1;
					end else if (sclFall && bitCount == 4'h8) begin
						bitCount <= 4'h0;
						state <= TRPS_ACK;
						sdaOe <= 1'b1;
						if (state == TRPS_ADDR) begin
							// Only answer when the address straps match
							if (shiftReg[7:1] != {SLAVE_ADDR_HI, slaveAddr}) begin
								state <= TRPS_IDLE;
								sdaOe <= 1'b0;
							end
							retState <= shiftReg[0] ? TRPS_RDBYTE : TRPS_CMD;
							if (shiftReg[0])
								shiftReg <= {4'h0, ctl.readyState, ctl.railStatus};
						end else if (state == TRPS_CMD) begin
							command <= shiftReg;
							retState <= TRPS_DATA;
						end else begin
							if (command == CMD_OFF) begin
								ctl.offRequest <= shiftReg[2:0];
								ctl.offStrobe <= 1'b1;
							end
							retState <= TRPS_IDLE;
						end
					end
				end
				TRPS_ACK: begin
					if (sclFall) begin
						state <= retState;
						// Read byte drives zeros only; ones float high
						sdaOe <= (retState == TRPS_RDBYTE) ? !shiftReg[7] : 1'b0;
					end
				end
				TRPS_RDBYTE: begin
					if (sclFall) begin
						bitCount <= bitCount + 4'h1;
						shiftReg <= {shiftReg[6:0], 1'b0};
						sdaOe <= (bitCount < 4'h7) ? !shiftReg[6] : 1'b0;
						if (bitCount == 4'h7)
							state <= TRPS_IDLE;
					end
				end
				default: begin
					state <= TRPS_IDLE;
					sdaOe <= 1'b0;
				end
				endcase
			end
		end
	end
endmodule : trps_smbus_slave

// >>> src/three_rail_power_sequencer.sv
// Top of the three-rail power sequencer
`timescale 1ns/1ps
module three_rail_power_sequencer
	import trps_pkg::*;
#(
	parameter int POWERUP_HOLD_CYCLES = POWERUP_HOLD_CYC,
	parameter int SEQ_GAP_CYCLES = SEQ_GAP_CYC
)(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic primarySupplyGood,
	input wire logic primary_switch_enable_in,
	input wire logic voltage_sequence_select,
	input wire logic timed_sequence_trigger,
	input wire logic feedbackAboveRef,
	input wire logic core_supply_monitor,
	input wire logic io_supply_monitor,
	input wire logic slave_addr_bit0,
	input wire logic slave_addr_bit1,
	input wire logic slave_addr_bit2,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	output logic readyOut,
	output logic readyOe,
	output logic primarySwitch,
	output logic coreSwitch,
	output logic ioSwitch
);
	// Zero counts would skip the hold and gap states the ordering relies on
	if (POWERUP_HOLD_CYCLES < 1 || SEQ_GAP_CYCLES < 1) begin : g_bad_counts
		$error("hold and gap counts must be at least one cycle");
	end

	localparam int SYNC_W = 11;
	logic [SYNC_W-1:0] syncA;
	logic [SYNC_W-1:0] syncB;
	wire [SYNC_W-1:0] rawIn = {primarySupplyGood, primary_switch_enable_in, voltage_sequence_select,
		timed_sequence_trigger, feedbackAboveRef, core_supply_monitor, io_supply_monitor,
		slave_addr_bit2, slave_addr_bit1, slave_addr_bit0, sclIn};
	logic sdaA;
	logic sdaB;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			// Address pins idle low like their pull-downs; clock idles high so no false edge follows reset
			syncA <= 11'h001;
			syncB <= 11'h001;
			sdaA <= 1'b1;
			sdaB <= 1'b1;
		end else begin
			syncA <= rawIn;
			syncB <= syncA;
			sdaA <= sdaIn;
			sdaB <= sdaA;
		end
	end

	wire supplyOk = syncB[10];
	wire primaryEn = syncB[9];
	wire voltMode = syncB[8];
	wire timedTrig = syncB[7];
	wire fbAbove = syncB[6];
	wire [2:0] slaveAddr = syncB[3:1];
	wire sclSync = syncB[0];

	trps_ctl_if ctl ();

	trps_smbus_slave u_slave (
		.clk_sys(clk_sys),
		.reset(reset),
		.sclSync(sclSync),
		.sdaSync(sdaB),
		.slaveAddr(slaveAddr),
		.sdaOe(sdaOe),
		.ctl(ctl.slave)
	);

	// Host turn-off latches per rail; cleared on supply loss, primary when its enable goes away, core and I/O when timed trigger and voltage select are both low
	logic [2:0] hostOff;
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			hostOff <= OFF_NONE;
		end else begin
			if (ctl.offStrobe)
				hostOff <= hostOff | ctl.offRequest;
			else if (!supplyOk)
				hostOff <= OFF_NONE;
			else begin
				if (!primaryEn)
					hostOff[0] <= 1'b0;
				if (!voltMode && !timedTrig)
					hostOff[2:1] <= 2'b00;
			end
		end
	end

	logic [31:0] holdCount;
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			holdCount <= 32'h0;
			readyOe <= 1'b1;
		end else if (!supplyOk) begin
			holdCount <= 32'h0;
			readyOe <= 1'b1;
		end else if (holdCount < 32'(POWERUP_HOLD_CYCLES)) begin
			holdCount <= holdCount + 32'h1;
			readyOe <= 1'b1;
		end else begin
			readyOe <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset)
			primarySwitch <= 1'b0;
		else
			primarySwitch <= supplyOk && primaryEn && !hostOff[0];
	end

	trps_seq_t seqState;
	logic [31:0] gapCount;
	wire secondaryReq = supplyOk && (voltMode ? fbAbove : timedTrig);
	wire gapDone = gapCount >= 32'(SEQ_GAP_CYCLES);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			seqState <= TRPS_OFF;
			gapCount <= 32'h0;
		end else begin
			gapCount <= gapDone ? gapCount : gapCount + 32'h1;
			case (seqState)
			TRPS_OFF: begin
				if (secondaryReq) begin
					seqState <= TRPS_CORE_UP;
					gapCount <= 32'h0;
				end
			end
			TRPS_CORE_UP: begin
				if (!secondaryReq) begin
					seqState <= TRPS_CORE_DOWN;
					gapCount <= 32'h0;
				end else if (voltMode || gapDone) begin
					seqState <= TRPS_ALL_UP;
				end
			end
			TRPS_ALL_UP: begin
				if (!secondaryReq) begin
					seqState <= TRPS_IO_DOWN;
					gapCount <= 32'h0;
				end
			end
			TRPS_IO_DOWN: begin
				if (!supplyOk || voltMode || gapDone) begin
					seqState <= TRPS_CORE_DOWN;
					gapCount <= 32'h0;
				end
			end
			TRPS_CORE_DOWN: begin
				if (!supplyOk || voltMode || gapDone)
					seqState <= TRPS_OFF;
			end
			default: begin
				seqState <= TRPS_OFF;
			end
			endcase
		end
	end

	// Lockout forces the rails low at once, bypassing the orderly ramp-down
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			coreSwitch <= 1'b0;
			ioSwitch <= 1'b0;
		end else begin
			coreSwitch <= supplyOk && !hostOff[1] && seqState != TRPS_OFF && seqState != TRPS_CORE_DOWN;
			ioSwitch <= supplyOk && !hostOff[2] && seqState == TRPS_ALL_UP;
		end
	end

	assign ctl.railStatus = {ioSwitch, coreSwitch, primarySwitch};
	assign ctl.readyState = !readyOe;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			readyOut <= 1'b0;
			sdaOut <= 1'b0;
		end else begin
			readyOut <= 1'b0;
			sdaOut <= 1'b0;
		end
	end
endmodule : three_rail_power_sequencer

// >>> tb/trps_chk.sv
// Port-level assertion checker for the three-rail power sequencer
`timescale 1ns/1ps
module trps_chk (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic primarySupplyGood,
	input wire logic primary_switch_enable_in,
	input wire logic voltage_sequence_select,
	input wire logic feedbackAboveRef,
	input wire logic readyOe,
	input wire logic primarySwitch,
	input wire logic coreSwitch,
	input wire logic ioSwitch
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	// Five samples cover the two-stage sync plus the output register
	sequence supplyLost;
		!primarySupplyGood [*5];
	endsequence
	sequence enableLow;
		!primary_switch_enable_in [*5];
	endsequence
	ready_lockout_a: assert property (supplyLost |-> readyOe)
		else $error("ready released in lockout");
	ready_hold_a: assert property ($fell(readyOe) |-> $past(primarySupplyGood, 8))
		else $error("ready released early");
	prim_on_a: assert property ($rose(primarySwitch) |-> $past(primary_switch_enable_in, 3) && $past(primarySupplyGood, 3))
		else $error("primary on without cause");
	prim_off_a: assert property (enableLow |-> !primarySwitch)
		else $error("primary on while disabled");
	lockout_all_a: assert property (supplyLost |-> !(primarySwitch || coreSwitch || ioSwitch))
		else $error("switch on in lockout");
	core_first_a: assert property ($rose(ioSwitch) |-> coreSwitch && $past(coreSwitch))
		else $error("io rail before core");
	core_last_a: assert property ($fell(coreSwitch) |-> !ioSwitch)
		else $error("core rail off before io");
	volt_core_a: assert property ((voltage_sequence_select && !feedbackAboveRef) [*5] |-> !$rose(coreSwitch))
		else $error("core on below reference");
endmodule : trps_chk
bind three_rail_power_sequencer trps_chk u_trps_chk (
	.clk_sys(clk_sys),
	.reset(reset),
	.primarySupplyGood(primarySupplyGood),
	.primary_switch_enable_in(primary_switch_enable_in),
	.voltage_sequence_select(voltage_sequence_select),
	.feedbackAboveRef(feedbackAboveRef),
	.readyOe(readyOe),
	.primarySwitch(primarySwitch),
	.coreSwitch(coreSwitch),
	.ioSwitch(ioSwitch)
);

// >>> tb/trps_host_model.sv
// Serial bus host model with an open-drain data line
`timescale 1ns/1ps
module trps_host_model (
	input wire logic clk_sys,
	input wire logic sdaOe,
	output logic sclIn,
	output logic sdaIn
);
	logic sdaPull = 1'b0;
	// Pull-up wins unless a party pulls low
	assign sdaIn = !(sdaPull || sdaOe);
	initial sclIn = 1'b1;
	// Long phases so the input sync never merges clock and data edges
	task automatic phase;
		repeat (8) @(negedge clk_sys);
	endtask : phase
	task automatic start;
		sdaPull = 1'b1;
		phase();
		sclIn = 1'b0;
		phase();
	endtask : start
	task automatic stop;
		sdaPull = 1'b1;
		phase();
		sclIn = 1'b1;
		phase();
		sdaPull = 1'b0;
		phase();
	endtask : stop
	task automatic bitOut(input logic b, output logic seen);
		sdaPull = !b;
		phase();
		sclIn = 1'b1;
		phase();
		seen = sdaIn;
		sclIn = 1'b0;
		phase();
	endtask : bitOut
	task automatic xfer(input logic [7:0] b, output logic [7:0] rd, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bitOut(b[i], rd[i]);
		end
		bitOut(1'b1, s);
		ack = !s;
	endtask : xfer
endmodule : trps_host_model

// >>> tb/three_rail_power_sequencer_bench.sv
// Self-checking bench for the three-rail power sequencer
`timescale 1ns/1ps
module three_rail_power_sequencer_bench;
	import trps_pkg::*;
	logic clk_sys, reset, primarySupplyGood, primary_switch_enable_in, voltage_sequence_select;
	logic timed_sequence_trigger, feedbackAboveRef, core_supply_monitor, io_supply_monitor;
	logic slave_addr_bit0, slave_addr_bit1, slave_addr_bit2, sclIn, sdaIn;
	logic sdaOut, sdaOe, readyOut, readyOe, primarySwitch, coreSwitch, ioSwitch;
	int mismatches = 0;
	int num_checks = 0;
	int cycles = 0;
	three_rail_power_sequencer #(.POWERUP_HOLD_CYCLES(8), .SEQ_GAP_CYCLES(4)) u_three_rail_power_sequencer (.*);
	trps_host_model u_host (.*);
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = !clk_sys;
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			report_and_stop();
		end
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc
	task automatic frame(input logic [7:0] addr, output logic ack, output logic [7:0] rd);
		logic a2;
		u_host.start();
		u_host.xfer(addr, rd, ack);
		u_host.xfer(8'hff, rd, a2);
		u_host.stop();
	endtask : frame
	task automatic t_powerup;
		primarySupplyGood = 1'b1;
		cyc(6);
		check("readyOe", readyOe, 1'b1);
		check("primarySwitch", primarySwitch, 1'b1);
		cyc(24);
		check("readyOe", readyOe, 1'b0);
		check("switches", {primarySwitch, coreSwitch, ioSwitch}, 8'h07);
	endtask : t_powerup
	task automatic t_enable;
		primary_switch_enable_in = 1'b0;
		cyc(6);
		check("primarySwitch", primarySwitch, 1'b0);
		primary_switch_enable_in = 1'b1;
		cyc(6);
		check("primarySwitch", primarySwitch, 1'b1);
	endtask : t_enable
	task automatic t_timedDown;
		timed_sequence_trigger = 1'b0;
		cyc(6);
		check("io core", {ioSwitch, coreSwitch}, 8'h01);
		cyc(12);
		check("coreSwitch", coreSwitch, 1'b0);
	endtask : t_timedDown
	task automatic t_voltage;
		voltage_sequence_select = 1'b1;
		cyc(10);
		check("coreSwitch", coreSwitch, 1'b0);
		feedbackAboveRef = 1'b1;
		cyc(10);
		check("core io", {coreSwitch, ioSwitch}, 8'h03);
		feedbackAboveRef = 1'b0;
		cyc(10);
		check("core io", {coreSwitch, ioSwitch}, 8'h00);
		voltage_sequence_select = 1'b0;
	endtask : t_voltage
	task automatic t_bus;
		logic ack;
		logic [7:0] rd;
		timed_sequence_trigger = 1'b1;
		cyc(30);
		for (int a = 0; a < 8; a++) begin
			{slave_addr_bit2, slave_addr_bit1, slave_addr_bit0} = a[2:0];
			cyc(4);
			frame({4'h4, a[2:0], 1'b1}, ack, rd);
			check("ack", ack, 1'b1);
			check("status", rd, 8'h0f);
			frame({4'h4, ~a[2:0], 1'b1}, ack, rd);
			check("foreign ack", ack, 1'b0);
		end
		u_host.start();
		u_host.xfer({4'h4, 3'h7, 1'b0}, rd, ack);
		u_host.xfer(CMD_OFF, rd, ack);
		u_host.xfer(8'h05, rd, ack);
		u_host.stop();
		check("data ack", ack, 1'b1);
		check("switches", {primarySwitch, coreSwitch, ioSwitch}, 8'h02);
		primarySupplyGood = 1'b0;
		cyc(6);
		check("switches", {primarySwitch, coreSwitch, ioSwitch}, 8'h00);
		check("readyOe", readyOe, 1'b1);
	endtask : t_bus
	initial begin
		reset = 1'b1;
		primarySupplyGood = 1'b0;
		primary_switch_enable_in = 1'b1;
		voltage_sequence_select = 1'b0;
		timed_sequence_trigger = 1'b1;
		feedbackAboveRef = 1'b0;
		core_supply_monitor = 1'b1;
		io_supply_monitor = 1'b1;
		{slave_addr_bit2, slave_addr_bit1, slave_addr_bit0} = 3'h0;
		cyc(2);
		reset = 1'b0;
		cyc(8);
		check("lockout", {readyOe, primarySwitch, coreSwitch, ioSwitch}, 8'h08);
		check("readyOut", readyOut, 1'b0);
		check("sdaOut", sdaOut, 1'b0);
		t_powerup();
		t_enable();
		t_timedDown();
		t_voltage();
		t_bus();
		report_and_stop();
	end
endmodule : three_rail_power_sequencer_bench
